// ---- sim/s2irq_regs_sva.sv ----
`timescale 1ns/100ps
`include "s2irq_defines.vh"

module s2irq_regs_chk (
    input wire        sys_clk,
    input wire        reset,
    input wire        clk_en,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire [17:0] s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        rx_dma_reset,
    input wire        irq
);
    wire [15:0] ar_idx = s_axi_araddr[`S2IRQ_IDX_MSB:`S2IRQ_IDX_LSB];
    wire        ar_err = ar_idx == `S2IRQ_IDX_ERR_A || ar_idx == `S2IRQ_IDX_ERR_B;
    wire        ar_map = ar_err || ar_idx == `S2IRQ_IDX_PENDING || ar_idx == `S2IRQ_IDX_ENABLE;
    wire        ar_go  = s_axi_arvalid && s_axi_arready;
    reg         rd_pend_reg;

    // the read answer comes a cycle later, so remember what it was aimed at
    always @(posedge sys_clk) begin
        if (reset)
            rd_pend_reg <= 1'b0;
        else if (ar_go)
            rd_pend_reg <= ar_idx == `S2IRQ_IDX_PENDING;
    end

    ////////////////////////////////////////
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence dma_rst_then_read_a;
        rx_dma_reset && clk_en ##1 ar_go && ar_idx == `S2IRQ_IDX_ERR_A;
    endsequence

    // the merge cycle only counts when the clock enable lets it run
    sequence wr_both_taken_then_run;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready ##1 clk_en;
    endsequence

    AST_ERR_UPPER_ZERO:
        assert property (ar_go && ar_err |=> s_axi_rdata[31:13] == 19'h0)
        else $error("offset read shows bits above the field");
    AST_ERR_ZERO_AFTER_DMA_RST:
        assert property (dma_rst_then_read_a |=> s_axi_rdata == 32'h0)
        else $error("offset not zero after dma reset");
    AST_EMPTY_PEND_NO_IRQ:
        assert property ($rose(s_axi_rvalid) && rd_pend_reg && s_axi_rdata == 32'h0 |-> !irq)
        else $error("irq high with nothing pending");
    AST_RD_ONE_CYCLE: assert property (ar_go |=> s_axi_rvalid)
        else $error("read answer late");
    AST_WR_TWO_CYCLES:
        assert property (wr_both_taken_then_run |=> s_axi_bvalid)
        else $error("write answer late");
    AST_BUSY_REFUSES: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answer pending");
    AST_FROZEN_REFUSES:
        assert property (!clk_en |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
        else $error("accepted while clock enable low");
    AST_UNMAPPED_SLVERR:
        assert property (ar_go && !ar_map
                         |=> s_axi_rresp == `S2IRQ_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    AST_RVALID_DROPS: assert property (s_axi_rvalid && s_axi_rready && clk_en |=> !s_axi_rvalid)
        else $error("read answer repeated");
endmodule // s2irq_regs_chk

bind s2irq_regs s2irq_regs_chk u_chk (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_dma_reset(rx_dma_reset),
    .irq(irq)
);

// ---- sim/tb_s2irq_regs.sv ----
`timescale 1ns/100ps
`include "s2irq_defines.vh"

module tb_s2irq_regs;
    localparam [17:0] A_ERR_A = {`S2IRQ_IDX_ERR_A, 2'b00};
    localparam [17:0] A_ERR_B = {`S2IRQ_IDX_ERR_B, 2'b00};
    localparam [17:0] A_PEND  = {`S2IRQ_IDX_PENDING, 2'b00};
    localparam [17:0] A_EN    = {`S2IRQ_IDX_ENABLE, 2'b00};
    localparam [1:0]  OK      = `S2IRQ_RESP_OKAY;
    localparam [1:0]  SLV     = `S2IRQ_RESP_SLVERR;

    reg         sys_clk, reset, clk_en, awvalid, wvalid, bready, arvalid, rready;
    reg  [17:0] awaddr, araddr, ea;
    reg  [31:0] wdata;
    reg  [3:0]  wstrb;
    reg  [12:0] ev, pos_a, pos_b, m, e, p;
    reg  [2:0]  ctl;
    reg  [1:0]  err_stb;
    reg  [33:0] exp_q[$];
    wire        awready, wready, bvalid, arready, rvalid, irq;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    integer     seed, err_count, num_checks, i, b;

    s2irq_regs dut (
        .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rx_has_data(ev[0]), .tx_buf_free(ev[1]), .tx_idle(ev[2]), .rx_overrun(ev[3]),
        .tx_underrun(ev[4]), .i2c_rx_done(ev[5]), .i2c_tx_done(ev[6]), .i2c_cmd_done(ev[7]),
        .i2c_no_ack(ev[8]), .rx_buf_a_unloaded(ev[9]), .rx_buf_b_unloaded(ev[10]),
        .tx_buf_a_unloaded(ev[11]), .tx_buf_b_unloaded(ev[12]),
        .rx_err_a_strobe(err_stb[0]), .rx_err_a_pos(pos_a), .rx_err_b_strobe(err_stb[1]),
        .rx_err_b_pos(pos_b), .rx_buf_a_reloaded(ctl[0]), .rx_buf_b_reloaded(ctl[1]),
        .rx_dma_reset(ctl[2]), .irq(irq)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////
    task check(input [33:0] seen, input [33:0] want);
        num_checks = num_checks + 1;
        if (seen !== want) begin
            err_count = err_count + 1;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task axi_wr(input [17:0] a, input [31:0] d, input [3:0] s, input [1:0] r);
        reg aw_d, w_d;
        exp_q.push_back({r, 32'h0});
        aw_d = 1'b0;
        w_d = 1'b0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // each channel released on its own handshake; slave may take them apart
        while (!(aw_d && w_d)) begin
            @(posedge sys_clk);
            if (awvalid && awready) aw_d = 1'b1;
            if (wvalid && wready) w_d = 1'b1;
            awvalid <= !aw_d;
            wvalid <= !w_d;
        end
        do @(posedge sys_clk); while (!bvalid);
        bready <= 1'b0;
        @(posedge sys_clk);
    endtask

    task axi_rd(input [17:0] a, input [31:0] d, input [1:0] r);
        exp_q.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (!rvalid);
        rready <= 1'b0;
        @(posedge sys_clk);
    endtask

    // one-cycle pulse on events, reload/dma controls and error strobes
    task pulse(input [12:0] evm, input [2:0] cm, input [1:0] sm, input [12:0] pp, input ce);
        ev <= evm;
        ctl <= cm;
        err_stb <= sm;
        pos_a <= pp;
        pos_b <= pp;
        clk_en <= ce;
        @(posedge sys_clk);
        ev <= 13'h0000;
        ctl <= 3'h0;
        err_stb <= 2'h0;
        clk_en <= 1'b1;
        @(posedge sys_clk);
    endtask

    task give_verdict;
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////
    always @(posedge sys_clk) begin
        if (bvalid && bready) check({bresp, 32'h0}, exp_q.pop_front());
        if (rvalid && rready) check({rresp, rdata}, exp_q.pop_front());
    end

    initial begin
        #100000;
        err_count = err_count + 1;
        give_verdict;
    end

    initial begin
        seed = 32'hfa10;
        err_count = 0;
        num_checks = 0;
        {awaddr, araddr, wdata, wstrb} = 72'h0;
        {ev, pos_a, pos_b, ctl, err_stb} = 44'h0;
        {awvalid, wvalid, bready, arvalid, rready, clk_en, reset} = 7'h03;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        axi_rd(A_ERR_A, 32'h0, OK);
        axi_rd(A_ERR_B, 32'h0, OK);
        axi_rd(A_EN, 32'h0, OK);
        axi_rd(18'h00100, 32'h0, SLV);
        axi_wr(18'h00100, 32'hffff_ffff, 4'hf, SLV);
        axi_wr(A_PEND, 32'h0000_1fff, 4'hf, OK);
        axi_rd(A_PEND, 32'h0, OK);
        for (i = 0; i < 13; i = i + 1) begin
            pulse(13'h0001 << i, 3'h0, 2'h0, 13'h0000, 1'b1);
            axi_rd(A_PEND, 32'h1 << i, OK);
        end
        // frozen cycle must not latch the event
        pulse(13'h0001, 3'h0, 2'h0, 13'h0000, 1'b0);
        axi_rd(A_PEND, 32'h0, OK);
        for (i = 0; i < 8; i = i + 1) begin
            e = 13'($random(seed));
            m = 13'($random(seed));
            axi_wr(A_EN, {19'h0, e}, 4'h3, OK);
            axi_rd(A_EN, {19'h0, e}, OK);
            pulse(m, 3'h0, 2'h0, 13'h0000, 1'b1);
            @(posedge sys_clk);
            check({33'h0, irq}, {33'h0, |(m & e)});
            axi_rd(A_PEND, {19'h0, m}, OK);
        end
        axi_wr(A_EN, 32'h0000_1fff, 4'h3, OK);
        axi_wr(A_EN, 32'h0000_0000, 4'h1, OK);
        axi_rd(A_EN, 32'h0000_1f00, OK);
        axi_wr(A_EN, 32'h0000_0000, 4'h2, OK);
        axi_rd(A_EN, 32'h0, OK);
        pulse(13'h1fff, 3'h0, 2'h0, 13'h0000, 1'b1);
        @(posedge sys_clk);
        check({33'h0, irq}, 34'h0);
        axi_rd(A_PEND, 32'h0000_1fff, OK);
        // event on the very edge that takes the clearing read must survive
        ev <= 13'h0008;
        fork
            axi_rd(A_PEND, 32'h0, OK);
            begin
                @(posedge sys_clk);
                ev <= 13'h0000;
            end
        join
        axi_rd(A_PEND, 32'h0000_0008, OK);
        for (b = 0; b < 2; b = b + 1) begin
            ea = b ? A_ERR_B : A_ERR_A;
            p = 13'($random(seed));
            pulse(13'h0000, 3'h0, 2'h1 << b, p, 1'b1);
            pulse(13'h0000, 3'h0, 2'h1 << b, ~p, 1'b1);
            axi_rd(ea, {19'h0, p}, OK);
            pulse(13'h0000, 3'h1 << b, 2'h0, 13'h0000, 1'b1);
            axi_rd(ea, {19'h0, p}, OK);
            pulse(13'h0200 << b, 3'h0, 2'h0, 13'h0000, 1'b1);
            axi_rd(ea, {19'h0, p}, OK);
            pulse(13'h0000, 3'h1 << b, 2'h0, 13'h0000, 1'b1);
            axi_rd(ea, 32'h0, OK);
            pulse(13'h0000, 3'h0, 2'h1 << b, ~p, 1'b1);
            axi_rd(ea, {19'h0, ~p}, OK);
            // read lands right after the dma reset edge
            ctl <= 3'h4;
            @(posedge sys_clk);
            ctl <= 3'h0;
            axi_rd(ea, 32'h0, OK);
            axi_rd(A_PEND, 32'h0200 << b, OK);
        end
        give_verdict;
    end
endmodule // tb_s2irq_regs

// ---- verilog/s2irq_defines.vh ----
// How it works
// (RULE_01) each rx dma buffer has a read-only 13-bit first-error byte offset
// (RULE_02) an offset reads zero while no receive error has hit that buffer
// (RULE_03) once captured, the offset holds; later errors in that buffer are ignored
// (RULE_04) capture re-arms only after unload then reload, or rx dma reset
// (RULE_05) enable bits 9..12: rx a, rx b, tx a, tx b buffer unloaded
// (RULE_06) enable bit 4 tx underrun, bit 3 rx overrun
// (RULE_07) enable bit 2 tx idle, bit 1 tx buffer free, bit 0 rx has data
// (RULE_08) enable bits 5..8: i2c rx done, tx done, cmd done, no ack
// (RULE_09) events set pending at enable's position; irq when pending and enable
`ifndef S2IRQ_DEFINES_VH
`define S2IRQ_DEFINES_VH

// register indices; byte address is four times the index
`define S2IRQ_IDX_ERR_A     16'h441a
`define S2IRQ_IDX_ERR_B     16'h441c
`define S2IRQ_IDX_PENDING   16'h460e
`define S2IRQ_IDX_ENABLE    16'h4626
`define S2IRQ_IDX_W         16
`define S2IRQ_ADDR_W        18
`define S2IRQ_IDX_LSB       2
`define S2IRQ_IDX_MSB       17

// field layout
`define S2IRQ_OFS_W         13
`define S2IRQ_OFS_MSB       12
`define S2IRQ_NUM_SRC       13
`define S2IRQ_SRC_MSB       12
`define S2IRQ_LANE0_MSB     7
`define S2IRQ_LANE1_LSB     8
`define S2IRQ_B_RX_VAL      0
`define S2IRQ_B_TX_FREE     1
`define S2IRQ_B_TX_IDLE     2
`define S2IRQ_B_RX_OVF      3
`define S2IRQ_B_TX_UND      4
`define S2IRQ_B_I2C_RX      5
`define S2IRQ_B_I2C_TX      6
`define S2IRQ_B_I2C_CMD     7
`define S2IRQ_B_I2C_NAK     8
`define S2IRQ_B_RX_ULD_A    9
`define S2IRQ_B_RX_ULD_B    10
`define S2IRQ_B_TX_ULD_A    11
`define S2IRQ_B_TX_ULD_B    12

// reset values and bus answers
`define S2IRQ_RST_OFS       13'h0000
`define S2IRQ_RST_SRC       13'h0000
`define S2IRQ_RST_DATA      32'h0000_0000
`define S2IRQ_RESP_OKAY     2'h0
`define S2IRQ_RESP_SLVERR   2'h2

`endif

// ---- verilog/s2irq_err_capture.v ----
`timescale 1ns/100ps
`include "s2irq_defines.vh"

module s2irq_err_capture (
    sys_clk,
    reset,
    clk_en,
    err_strobe,
    err_pos,
    buf_unloaded,
    buf_reloaded,
    dma_reset,
    err_offset
);
    input  wire                      sys_clk;
    input  wire                      reset;
    input  wire                      clk_en;
    input  wire                      err_strobe;
    input  wire [`S2IRQ_OFS_MSB:0]   err_pos;
    input  wire                      buf_unloaded;
    input  wire                      buf_reloaded;
    input  wire                      dma_reset;
    output wire [`S2IRQ_OFS_MSB:0]   err_offset;

    localparam [1:0] ST_ARMED    = 2'h0;
    localparam [1:0] ST_HELD     = 2'h1;
    localparam [1:0] ST_UNLOADED = 2'h2;

    reg [1:0]                state_reg;
    reg [1:0]                state_next;
    reg [`S2IRQ_OFS_MSB:0]   offset_reg;
    reg [`S2IRQ_OFS_MSB:0]   offset_next;

    assign err_offset = offset_reg; // RULE_01

    always @* begin
        state_next  = state_reg;
        offset_next = offset_reg;
        if (dma_reset) begin
            state_next  = ST_ARMED; // RULE_04
            offset_next = `S2IRQ_RST_OFS; // RULE_02
        end else begin
            case (state_reg)
                ST_ARMED: begin
                    if (err_strobe) begin
                        state_next  = ST_HELD;
                        offset_next = err_pos;
                    end
                end
                ST_HELD: begin
                    // errors ignored here, only an unload or rx dma reset moves on
                    if (buf_unloaded) begin // RULE_03
                        state_next = ST_UNLOADED;
                    end
                end
                ST_UNLOADED: begin
                    // fresh buffer contents: no error yet, so back to zero
                    if (buf_reloaded) begin // RULE_04
                        state_next  = ST_ARMED;
                        offset_next = `S2IRQ_RST_OFS; // RULE_02
                    end
                end
                default: begin
                    state_next  = ST_ARMED;
                    offset_next = `S2IRQ_RST_OFS;
                end
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            state_reg  <= ST_ARMED;
            offset_reg <= `S2IRQ_RST_OFS;
        end else if (clk_en) begin
            state_reg  <= state_next;
            offset_reg <= offset_next;
        end
    end
endmodule // s2irq_err_capture

// ---- verilog/s2irq_regs.v ----
`timescale 1ns/100ps
`include "s2irq_defines.vh"

module s2irq_regs (
    sys_clk,
    reset,
    clk_en,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    rx_has_data,
    tx_buf_free,
    tx_idle,
    rx_overrun,
    tx_underrun,
    i2c_rx_done,
    i2c_tx_done,
    i2c_cmd_done,
    i2c_no_ack,
    rx_buf_a_unloaded,
    rx_buf_b_unloaded,
    tx_buf_a_unloaded,
    tx_buf_b_unloaded,
    rx_err_a_strobe,
    rx_err_a_pos,
    rx_err_b_strobe,
    rx_err_b_pos,
    rx_buf_a_reloaded,
    rx_buf_b_reloaded,
    rx_dma_reset,
    irq
);
    input  wire                        sys_clk;
    input  wire                        reset;
    input  wire                        clk_en;
    input  wire [`S2IRQ_ADDR_W-1:0]    s_axi_awaddr;
    input  wire                        s_axi_awvalid;
    output wire                        s_axi_awready;
    input  wire [31:0]                 s_axi_wdata;
    input  wire [3:0]                  s_axi_wstrb;
    input  wire                        s_axi_wvalid;
    output wire                        s_axi_wready;
    output wire [1:0]                  s_axi_bresp;
    output wire                        s_axi_bvalid;
    input  wire                        s_axi_bready;
    input  wire [`S2IRQ_ADDR_W-1:0]    s_axi_araddr;
    input  wire                        s_axi_arvalid;
    output wire                        s_axi_arready;
    output wire [31:0]                 s_axi_rdata;
    output wire [1:0]                  s_axi_rresp;
    output wire                        s_axi_rvalid;
    input  wire                        s_axi_rready;
    input  wire                        rx_has_data;
    input  wire                        tx_buf_free;
    input  wire                        tx_idle;
    input  wire                        rx_overrun;
    input  wire                        tx_underrun;
    input  wire                        i2c_rx_done;
    input  wire                        i2c_tx_done;
    input  wire                        i2c_cmd_done;
    input  wire                        i2c_no_ack;
    input  wire                        rx_buf_a_unloaded;
    input  wire                        rx_buf_b_unloaded;
    input  wire                        tx_buf_a_unloaded;
    input  wire                        tx_buf_b_unloaded;
    input  wire                        rx_err_a_strobe;
    input  wire [`S2IRQ_OFS_MSB:0]     rx_err_a_pos;
    input  wire                        rx_err_b_strobe;
    input  wire [`S2IRQ_OFS_MSB:0]     rx_err_b_pos;
    input  wire                        rx_buf_a_reloaded;
    input  wire                        rx_buf_b_reloaded;
    input  wire                        rx_dma_reset;
    output wire                        irq;

    ////////////////////////////////////////////////////////////////////////

    // address decode, shared by the read and the write path
    function addr_hit;
        input [`S2IRQ_ADDR_W-1:0] addr;
        input [`S2IRQ_IDX_W-1:0]  idx;
        begin
            addr_hit = (addr[`S2IRQ_IDX_MSB:`S2IRQ_IDX_LSB] == idx);
        end
    endfunction

    function addr_mapped;
        input [`S2IRQ_ADDR_W-1:0] addr;
        begin
            addr_mapped = addr_hit(addr, `S2IRQ_IDX_ERR_A)
                        | addr_hit(addr, `S2IRQ_IDX_ERR_B)
                        | addr_hit(addr, `S2IRQ_IDX_PENDING)
                        | addr_hit(addr, `S2IRQ_IDX_ENABLE);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////

    wire [`S2IRQ_SRC_MSB:0]         event_vec;
    wire [1:0]                      cap_strobe;
    wire [2*`S2IRQ_OFS_W-1:0]       cap_pos;
    wire [1:0]                      cap_unloaded;
    wire [1:0]                      cap_reloaded;
    wire [2*`S2IRQ_OFS_W-1:0]       cap_offset;

    // one bit per source, each at its enable's position
    assign event_vec[`S2IRQ_B_RX_VAL]   = rx_has_data; // RULE_07
    assign event_vec[`S2IRQ_B_TX_FREE]  = tx_buf_free; // RULE_07
    assign event_vec[`S2IRQ_B_TX_IDLE]  = tx_idle; // RULE_07
    assign event_vec[`S2IRQ_B_RX_OVF]   = rx_overrun; // RULE_06
    assign event_vec[`S2IRQ_B_TX_UND]   = tx_underrun; // RULE_06
    assign event_vec[`S2IRQ_B_I2C_RX]   = i2c_rx_done; // RULE_08
    assign event_vec[`S2IRQ_B_I2C_TX]   = i2c_tx_done; // RULE_08
    assign event_vec[`S2IRQ_B_I2C_CMD]  = i2c_cmd_done; // RULE_08
    assign event_vec[`S2IRQ_B_I2C_NAK]  = i2c_no_ack; // RULE_08
    assign event_vec[`S2IRQ_B_RX_ULD_A] = rx_buf_a_unloaded; // RULE_05
    assign event_vec[`S2IRQ_B_RX_ULD_B] = rx_buf_b_unloaded; // RULE_05
    assign event_vec[`S2IRQ_B_TX_ULD_A] = tx_buf_a_unloaded; // RULE_05
    assign event_vec[`S2IRQ_B_TX_ULD_B] = tx_buf_b_unloaded; // RULE_05

    assign cap_strobe   = {rx_err_b_strobe, rx_err_a_strobe};
    assign cap_pos      = {rx_err_b_pos, rx_err_a_pos};
    assign cap_unloaded = {rx_buf_b_unloaded, rx_buf_a_unloaded};
    assign cap_reloaded = {rx_buf_b_reloaded, rx_buf_a_reloaded};

    ////////////////////////////////////////////////////////////////////////

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_cap
            s2irq_err_capture u_cap (
                .sys_clk      (sys_clk),
                .reset        (reset),
                .clk_en       (clk_en),
                .err_strobe   (cap_strobe[gi]),
                .err_pos      (cap_pos[gi*`S2IRQ_OFS_W +: `S2IRQ_OFS_W]),
                .buf_unloaded (cap_unloaded[gi]),
                .buf_reloaded (cap_reloaded[gi]),
                .dma_reset    (rx_dma_reset),
                .err_offset   (cap_offset[gi*`S2IRQ_OFS_W +: `S2IRQ_OFS_W])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order

    reg                         aw_full_reg;
    reg [`S2IRQ_ADDR_W-1:0]     aw_addr_reg;
    reg                         w_full_reg;
    reg [31:0]                  w_data_reg;
    reg [3:0]                   w_strb_reg;
    reg                         bvalid_reg;
    reg [1:0]                   bresp_reg;
    reg [`S2IRQ_SRC_MSB:0]      enable_reg;
    reg [`S2IRQ_SRC_MSB:0]      enable_next;

    wire aw_take;
    wire w_take;
    wire do_write;

    // ready drops with clk_en so nothing is taken while state is frozen
    assign s_axi_awready = clk_en & ~aw_full_reg & ~bvalid_reg;
    assign s_axi_wready  = clk_en & ~w_full_reg & ~bvalid_reg;
    assign aw_take  = s_axi_awvalid & s_axi_awready;
    assign w_take   = s_axi_wvalid & s_axi_wready;
    assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    always @* begin
        enable_next = enable_reg;
        if (do_write && addr_hit(aw_addr_reg, `S2IRQ_IDX_ENABLE)) begin
            if (w_strb_reg[0]) begin
                enable_next[`S2IRQ_LANE0_MSB:0] =
                    w_data_reg[`S2IRQ_LANE0_MSB:0]; // RULE_05
            end
            // byte lanes 2 and 3 carry no enable bits
            if (w_strb_reg[1]) begin
                enable_next[`S2IRQ_SRC_MSB:`S2IRQ_LANE1_LSB] =
                    w_data_reg[`S2IRQ_SRC_MSB:`S2IRQ_LANE1_LSB]; // RULE_05
            end
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= {`S2IRQ_ADDR_W{1'b0}};
            w_full_reg  <= 1'b0;
            w_data_reg  <= `S2IRQ_RST_DATA;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `S2IRQ_RESP_OKAY;
            enable_reg  <= `S2IRQ_RST_SRC;
        end else if (clk_en) begin
            enable_reg <= enable_next;
            if (aw_take) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                // read-only and pending offsets accept and ignore writes
                bresp_reg   <= addr_mapped(aw_addr_reg) ? `S2IRQ_RESP_OKAY
                                                        : `S2IRQ_RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel and sticky pending flags

    reg                         rvalid_reg;
    reg [31:0]                  rdata_reg;
    reg [1:0]                   rresp_reg;
    reg [`S2IRQ_SRC_MSB:0]      pending_reg;
    reg [`S2IRQ_SRC_MSB:0]      pending_next;
    reg [31:0]                  rd_mux;
    reg                         irq_reg;

    wire ar_take;
    wire rd_clears;

    assign s_axi_arready = clk_en & ~rvalid_reg;
    assign ar_take   = s_axi_arvalid & s_axi_arready;
    assign rd_clears = ar_take & addr_hit(s_axi_araddr, `S2IRQ_IDX_PENDING);
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;
    assign irq          = irq_reg;

    // unmapped offsets fall through to zero
    always @* begin
        rd_mux = `S2IRQ_RST_DATA;
        if (addr_hit(s_axi_araddr, `S2IRQ_IDX_ERR_A)) begin
            rd_mux[`S2IRQ_OFS_MSB:0] = cap_offset[`S2IRQ_OFS_MSB:0]; // RULE_01
        end else if (addr_hit(s_axi_araddr, `S2IRQ_IDX_ERR_B)) begin
            rd_mux[`S2IRQ_OFS_MSB:0] =
                cap_offset[`S2IRQ_OFS_W +: `S2IRQ_OFS_W]; // RULE_01
        end else if (addr_hit(s_axi_araddr, `S2IRQ_IDX_PENDING)) begin
            rd_mux[`S2IRQ_SRC_MSB:0] = pending_reg;
        end else if (addr_hit(s_axi_araddr, `S2IRQ_IDX_ENABLE)) begin
            rd_mux[`S2IRQ_SRC_MSB:0] = enable_reg;
        end
    end

    // limitation: a read clears the whole word, so software must act on
    // every bit it saw; there is no per-bit clear
    // an event in the cycle of the clearing read survives: set wins
    always @* begin
        pending_next = pending_reg;
        if (rd_clears) begin
            pending_next = `S2IRQ_RST_SRC;
        end
        pending_next = pending_next | event_vec; // RULE_09
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            rvalid_reg  <= 1'b0;
            rdata_reg   <= `S2IRQ_RST_DATA;
            rresp_reg   <= `S2IRQ_RESP_OKAY;
            pending_reg <= `S2IRQ_RST_SRC;
            irq_reg     <= 1'b0;
        end else if (clk_en) begin
            pending_reg <= pending_next;
            // registered so the line never glitches; costs one cycle
            irq_reg     <= |(pending_reg & enable_reg); // RULE_09
            if (ar_take) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_mux;
                rresp_reg  <= addr_mapped(s_axi_araddr) ? `S2IRQ_RESP_OKAY
                                                        : `S2IRQ_RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end
endmodule // s2irq_regs
